// ===== dacc_pkg.sv
// shared constants for the dac control register logic
package dacc_pkg;
    // =====================================================
    // frame layout
    localparam int FRAME_BITS = 24;
    localparam int ADDR_HI = 19;
    localparam int ADDR_LO = 16;
    localparam int FIXED_BIT = 20;
    localparam logic [3:0] ADDR_MODE_CONFIGURATION = 4'h4;
    localparam logic [3:0] ADDR_FULL_RESET = 4'hf;
    localparam logic [3:0] ADDR_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] ADDR_UPDATE_DAC = 4'h2;
    // =====================================================
    // mode_configuration field positions
    localparam int CLEAR_SEL_HI = 10;
    localparam int CLEAR_SEL_LO = 9;
    localparam int EXTEND_POS = 8;
    localparam int TWOS_POS = 7;
    localparam int THERMAL_POS = 6;
    localparam int REF_POS = 5;
    localparam int PWRUP_SEL_HI = 4;
    localparam int PWRUP_SEL_LO = 3;
    localparam int SPAN_HI = 2;
    localparam int SPAN_LO = 0;
    localparam logic [10:0] MODE_RESET = 11'h000;
    // =====================================================
    // scale levels and the die temperature limit
    localparam logic [1:0] SCALE_ZERO = 2'h0;
    localparam logic [1:0] SCALE_MID = 2'h1;
    localparam logic [1:0] SCALE_FULL = 2'h2;
    localparam int SHUTDOWN_TEMP_C = 150;
    localparam int CLAMP_OHMS = 1000;
    // =====================================================
    // output span encodings
    typedef enum logic [2:0] {
        SPAN_PM10, SPAN_U10, SPAN_PM5, SPAN_U5,
        SPAN_OFS75, SPAN_PM3, SPAN_U16, SPAN_U20
    } dacc_span_t;
    // three-level scale decode for clear and power-up selects
    function automatic logic [1:0] dacc_scale(input logic [1:0] sel);
        dacc_scale = (sel == 2'h0) ? SCALE_ZERO : (sel == 2'h1) ? SCALE_MID : SCALE_FULL;
    endfunction
endpackage

// ===== dacc_shift.sv
// serial frame capture: shift register and bit counter
`timescale 1ns/100ps
`default_nettype none
module dacc_shift
    import dacc_pkg::*;
#(
    parameter int WIDTH = FRAME_BITS
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial link, sampled on sys_clk
    input wire logic sync_n,
    input wire logic sdi,
    // captured frame
    output logic [WIDTH-1:0] frame,
    output logic frame_done
);
    logic [WIDTH-1:0] shreg, next_shreg;
    logic [5:0] count, next_count;
    logic sync_q, next_sync_q;
    logic [WIDTH-1:0] next_frame;
    logic next_done;

    // shift msb first while framed, latch on rising sync
    always_comb
    begin
        next_shreg = shreg;
        next_count = count;
        next_sync_q = sync_n;
        next_frame = frame;
        next_done = 1'b0;
        if (!sync_n)
        begin
            next_shreg = {shreg[WIDTH-2:0], sdi}; // R15
            if (count < 6'(WIDTH))
                next_count = count + 6'h01;
        end
        else if (!sync_q)
        begin
            next_count = 6'h00;
            if (count == 6'(WIDTH))
            begin
                next_frame = shreg; // R15 R16
                next_done = 1'b1;
            end
        end
    end

    // register the shifter
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            shreg <= '0;
            count <= 6'h00;
            sync_q <= 1'b1;
            frame <= '0;
            frame_done <= 1'b0;
        end
        else
        begin
            shreg <= next_shreg;
            count <= next_count;
            sync_q <= next_sync_q;
            frame <= next_frame;
            frame_done <= next_done;
        end
    end

    // short frames never latch
    property p_short_no_latch;
        @(posedge sys_clk) disable iff (rst)
        (sync_n && !sync_q && count != 6'(WIDTH)) |=> !frame_done;
    endproperty
    a_short_no_latch: assert property (p_short_no_latch) else $error("short frame latched"); // R16
endmodule
`default_nettype wire

// ===== dacc_decode.sv
// command decode of a latched frame
`timescale 1ns/100ps
`default_nettype none
module dacc_decode
    import dacc_pkg::*;
(
    // latched frame
    input wire logic [FRAME_BITS-1:0] frame,
    input wire logic frame_done,
    // decoded commands
    output logic write_mode,
    output logic full_reset,
    output logic dac_load
);
    logic fixed_ok;
    logic [3:0] addr;

    // bit 20 must be zero; top three bits and 15:11 ignored
    always_comb
    begin
        addr = frame[ADDR_HI:ADDR_LO];
        fixed_ok = !frame[FIXED_BIT]; // R4
        write_mode = frame_done && fixed_ok && addr == ADDR_MODE_CONFIGURATION; // R4 R16
        full_reset = frame_done && fixed_ok && addr == ADDR_FULL_RESET;
        dac_load = frame_done && fixed_ok
            && (addr == ADDR_WRITE_UPDATE || addr == ADDR_UPDATE_DAC);
    end
endmodule
`default_nettype wire

// ===== dacc_control.sv
// control register logic of a serial voltage-output dac
// =====================================================
// What this block does
// (R1) reset clamps output, buffer powered down
// (R2) control write releases clamp, powers buffer
// (R3) host resets before changing output range
// (R4) frame: bit20 zero, address 0100, ignore 15:11
// (R5) field positions for all control bits
// (R6) clear select: zero, mid, full scale
// (R7) overrange bit enables five percent extension
// (R8) bipolar coding bit selects twos complement
// (R9) thermal bit powers supply down when hot
// (R10) reference enable switches internal reference
// (R11) power-up select: zero, mid, full scale
// (R12) three-bit range picks one of eight spans
// (R13) binary and twos complement differ by msb
// (R14) clear falling edge forces clear value
// (R15) 24-bit msb-first frame, latched on sync
// (R16) apply fields only after full matching frame
`timescale 1ns/100ps
`default_nettype none
module dacc_control
    import dacc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial port
    input wire logic sync_n,
    input wire logic sdi,
    // hardware pins and sensors
    input wire logic clear_n,
    input wire logic over_temp,
    // dac code from the data path, loaded by commands
    input wire logic [15:0] dac_code,
    // analog controls
    output logic output_clamp,
    output logic buffer_powered,
    output logic [1:0] clear_value_select,
    output logic range_extension_enable,
    output logic bipolar_twos_coding,
    output logic thermal_supply_shutdown,
    output logic internal_reference_on,
    output logic [1:0] powerup_value_select,
    output dacc_span_t output_span_select,
    output logic digital_supply_off,
    output logic [1:0] forced_scale,
    output logic forced_active,
    output logic [15:0] offset_code,
    output logic [15:0] mode_configuration
);
    // =====================================================
    // frame capture and decode
    logic [FRAME_BITS-1:0] frame;
    logic frame_done;
    logic write_mode;
    logic full_reset;
    logic dac_load;

    dacc_shift #(
        .WIDTH(FRAME_BITS)
    ) u_shift (
        .sys_clk(sys_clk),
        .rst(rst),
        .sync_n(sync_n),
        .sdi(sdi),
        .frame(frame),
        .frame_done(frame_done)
    );

    dacc_decode u_decode (
        .frame(frame),
        .frame_done(frame_done),
        .write_mode(write_mode),
        .full_reset(full_reset),
        .dac_load(dac_load)
    );

    // =====================================================
    // mode state
    typedef enum logic {ST_CLAMPED, ST_ACTIVE} dacc_state_t;
    dacc_state_t state, next_state;
    logic [10:0] mode, next_mode;
    logic clear_q, next_clear_q;
    logic forced, next_forced;
    logic [1:0] forced_lvl, next_forced_lvl;

    // state and field updates from decoded frames
    always_comb
    begin
        next_state = state;
        next_mode = mode;
        next_clear_q = clear_n;
        next_forced = forced;
        next_forced_lvl = forced_lvl;
        case (state)
            ST_CLAMPED:
            begin
                if (write_mode)
                begin
                    next_mode = frame[10:0]; // R5 R16
                    next_state = ST_ACTIVE; // R2
                    next_forced_lvl = dacc_scale(frame[PWRUP_SEL_HI:PWRUP_SEL_LO]); // R11
                    next_forced = 1'b1;
                end
            end
            ST_ACTIVE:
            begin
                if (write_mode)
                    next_mode = frame[10:0]; // R5 R16
            end
            default:
                next_state = ST_CLAMPED;
        endcase
        // falling clear edge forces the clear level until a dac load
        if (clear_q && !clear_n)
        begin
            next_forced = 1'b1; // R14
            next_forced_lvl = dacc_scale(mode[CLEAR_SEL_HI:CLEAR_SEL_LO]); // R6
        end
        else if (dac_load)
            next_forced = 1'b0; // R14
        // software full reset returns everything to power-on
        if (full_reset)
        begin
            next_state = ST_CLAMPED; // R1
            next_mode = MODE_RESET;
            next_forced = 1'b0;
            next_forced_lvl = SCALE_ZERO;
        end
    end

    // register mode state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_CLAMPED; // R1
            mode <= MODE_RESET;
            clear_q <= 1'b1;
            forced <= 1'b0;
            forced_lvl <= SCALE_ZERO;
        end
        else
        begin
            state <= next_state;
            mode <= next_mode;
            clear_q <= next_clear_q;
            forced <= next_forced;
            forced_lvl <= next_forced_lvl;
        end
    end

    // =====================================================
    // field outputs
    always_comb
    begin
        output_clamp = (state == ST_CLAMPED); // R1 R2
        buffer_powered = (state == ST_ACTIVE); // R1 R2
        clear_value_select = mode[CLEAR_SEL_HI:CLEAR_SEL_LO]; // R6
        range_extension_enable = mode[EXTEND_POS]; // R7
        bipolar_twos_coding = mode[TWOS_POS]; // R8
        thermal_supply_shutdown = mode[THERMAL_POS]; // R9
        internal_reference_on = mode[REF_POS]; // R10
        powerup_value_select = mode[PWRUP_SEL_HI:PWRUP_SEL_LO]; // R11
        output_span_select = dacc_span_t'(mode[SPAN_HI:SPAN_LO]); // R12
        // over_temp means die above the shutdown temperature
        digital_supply_off = over_temp && mode[THERMAL_POS]; // R9
        forced_scale = forced_lvl;
        forced_active = forced;
        mode_configuration = {5'h00, mode};
    end

    // spans that reach below ground take signed codes
    function automatic logic span_is_bipolar(input dacc_span_t span);
        case (span)
            SPAN_PM10, SPAN_PM5, SPAN_OFS75, SPAN_PM3:
                span_is_bipolar = 1'b1;
            default:
                span_is_bipolar = 1'b0;
        endcase
    endfunction

    // binary code seen by the converter core; unipolar spans stay binary
    always_comb
    begin
        offset_code = dac_code;
        if (mode[TWOS_POS] && span_is_bipolar(output_span_select)) // R8
            offset_code = {~dac_code[15], dac_code[14:0]}; // R8 R13
    end

    // =====================================================
    // checks
    sequence s_mode_write;
        write_mode && !full_reset;
    endsequence

    sequence s_released;
        !output_clamp && buffer_powered;
    endsequence

    property p_reset_clamps;
        @(posedge sys_clk) disable iff (rst)
        full_reset |=> output_clamp && !buffer_powered;
    endproperty
    a_reset_clamps: assert property (p_reset_clamps) else $error("reset left output free"); // R1

    property p_write_releases;
        @(posedge sys_clk) disable iff (rst)
        s_mode_write |=> s_released;
    endproperty
    a_write_releases: assert property (p_write_releases) else $error("write did not release"); // R2

    property p_stay_clamped;
        @(posedge sys_clk) disable iff (rst)
        (output_clamp && !write_mode) |=> output_clamp;
    endproperty
    a_stay_clamped: assert property (p_stay_clamped) else $error("clamp left without write"); // R2

    property p_fields_loaded;
        @(posedge sys_clk) disable iff (rst)
        s_mode_write |=> mode_configuration[10:0] == $past(frame[10:0]);
    endproperty
    a_fields_loaded: assert property (p_fields_loaded) else $error("fields not loaded"); // R5

    property p_fields_hold;
        @(posedge sys_clk) disable iff (rst)
        (!write_mode && !full_reset) |=> $stable(mode_configuration);
    endproperty
    a_fields_hold: assert property (p_fields_hold) else $error("fields changed"); // R16

    property p_clear_level;
        @(posedge sys_clk) disable iff (rst)
        (clear_q && !clear_n && !full_reset) |=>
            forced_active && forced_scale == dacc_scale($past(clear_value_select));
    endproperty
    a_clear_level: assert property (p_clear_level) else $error("clear level wrong"); // R6

    property p_clear_holds;
        @(posedge sys_clk) disable iff (rst)
        (forced_active && !dac_load && !full_reset) |=> forced_active;
    endproperty
    a_clear_holds: assert property (p_clear_holds) else $error("clear level dropped"); // R14

    property p_powerup_level;
        @(posedge sys_clk) disable iff (rst)
        s_mode_write and (output_clamp && !(clear_q && !clear_n)) |=>
            forced_scale == dacc_scale($past(frame[PWRUP_SEL_HI:PWRUP_SEL_LO]));
    endproperty
    a_powerup_level: assert property (p_powerup_level) else $error("power-up level wrong"); // R11

    property p_twos_msb;
        @(posedge sys_clk) disable iff (rst)
        (bipolar_twos_coding && span_is_bipolar(output_span_select)) |->
            offset_code[15] != dac_code[15];
    endproperty
    a_twos_msb: assert property (p_twos_msb) else $error("msb not inverted"); // R13

    property p_supply;
        @(posedge sys_clk) disable iff (rst)
        (over_temp && !thermal_supply_shutdown) |-> !digital_supply_off;
    endproperty
    a_supply: assert property (p_supply) else $error("supply cut with bit clear"); // R9

    property p_supply_cut;
        @(posedge sys_clk) disable iff (rst)
        (over_temp && thermal_supply_shutdown) |-> digital_supply_off;
    endproperty
    a_supply_cut: assert property (p_supply_cut) else $error("supply kept when hot"); // R9

    property p_straight_code;
        @(posedge sys_clk) disable iff (rst)
        !(bipolar_twos_coding && span_is_bipolar(output_span_select)) |-> offset_code == dac_code;
    endproperty
    a_straight_code: assert property (p_straight_code) else $error("binary code altered"); // R8

    property p_reset_defaults;
        @(posedge sys_clk) disable iff (rst)
        full_reset |=> mode_configuration == 16'h0000 && !forced_active;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset kept fields"); // R1

    property p_stays_active;
        @(posedge sys_clk) disable iff (rst)
        (buffer_powered && !full_reset) |=> buffer_powered;
    endproperty
    a_stays_active: assert property (p_stays_active) else $error("buffer dropped"); // R2

    property p_load_ends_force;
        @(posedge sys_clk) disable iff (rst)
        (dac_load && !(clear_q && !clear_n) && !full_reset) |=> !forced_active;
    endproperty
    a_load_ends_force: assert property (p_load_ends_force) else $error("load kept level"); // R14

    property p_span_loaded;
        @(posedge sys_clk) disable iff (rst)
        s_mode_write |=>
            output_span_select == dacc_span_t'($past(frame[SPAN_HI:SPAN_LO]));
    endproperty
    a_span_loaded: assert property (p_span_loaded) else $error("span not loaded"); // R12

    property p_ref_ext_loaded;
        @(posedge sys_clk) disable iff (rst)
        s_mode_write |=> internal_reference_on == $past(frame[REF_POS])
            && range_extension_enable == $past(frame[EXTEND_POS]);
    endproperty
    a_ref_ext_loaded: assert property (p_ref_ext_loaded) else $error("ref or ext wrong"); // R7 R10
endmodule
`default_nettype wire

// ===== dacc_host.sv
// host serial port model that shifts frames into the device
`timescale 1ns/100ps
`default_nettype none
module dacc_host
(
    // clock from the bench
    input wire logic sys_clk,
    // serial link to the device
    output logic sync_n,
    output logic sdi
);
    // ====
    // frame sender
    initial
    begin
        sync_n = 1'b1;
        sdi = 1'b0;
    end
    // sends the top nbits of w msb first, then releases the strobe
    task automatic send(input logic [23:0] w, input int nbits);
        @(posedge sys_clk);
        #1;
        sync_n = 1'b0;
        for (int k = 0; k < nbits; k++)
        begin
            sdi = w[23-k];
            @(posedge sys_clk);
            #1;
        end
        sync_n = 1'b1;
        sdi = ~sdi; // idle line shows no stale data
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the dac control register logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import dacc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst, clear_n, over_temp;
    logic [15:0] dac_code;
    logic sync_n, sdi, output_clamp, buffer_powered, range_extension_enable;
    logic bipolar_twos_coding, thermal_supply_shutdown, internal_reference_on;
    logic digital_supply_off, forced_active;
    logic [1:0] clear_value_select, powerup_value_select, forced_scale;
    logic [15:0] offset_code, mode_configuration, d, saved;
    dacc_span_t output_span_select;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    // ====
    // clock, device and host
    always #20 sys_clk = ~sys_clk;
    dacc_host dacc_host_i (.sys_clk(sys_clk), .sync_n(sync_n), .sdi(sdi));
    dacc_control dacc_control_i (.sys_clk(sys_clk), .rst(rst), .sync_n(sync_n),
        .sdi(sdi), .clear_n(clear_n), .over_temp(over_temp), .dac_code(dac_code),
        .output_clamp(output_clamp), .buffer_powered(buffer_powered),
        .clear_value_select(clear_value_select),
        .range_extension_enable(range_extension_enable),
        .bipolar_twos_coding(bipolar_twos_coding),
        .thermal_supply_shutdown(thermal_supply_shutdown),
        .internal_reference_on(internal_reference_on),
        .powerup_value_select(powerup_value_select),
        .output_span_select(output_span_select), .digital_supply_off(digital_supply_off),
        .forced_scale(forced_scale), .forced_active(forced_active),
        .offset_code(offset_code), .mode_configuration(mode_configuration));
    // ====
    // checking helpers
    function automatic logic [1:0] exp_scale(input logic [1:0] s);
        return (s == 2'h0) ? 2'h0 : (s == 2'h1) ? 2'h1 : 2'h2;
    endfunction
    // spans 000, 010, 100 and 101 reach below ground
    function automatic logic exp_bipolar(input logic [2:0] r);
        return r == 3'h0 || r == 3'h2 || r == 3'h4 || r == 3'h5;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    // ====
    // main sequence
    initial
    begin
        rst = 1'b1;
        clear_n = 1'b1;
        over_temp = 1'b0;
        dac_code = 16'h0000;
        void'($urandom(39));
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk({output_clamp, buffer_powered}, 16'h2);
        chk(mode_configuration, 16'h0000);
        $display("test reset done");
        for (int s = 0; s < 8; s++)
        begin
            dacc_host_i.send({3'($urandom), 1'b0, 4'hf, 16'($urandom)}, 24);
            chk({output_clamp, buffer_powered}, 16'h2);
            d = 16'($urandom);
            d[2:0] = 3'(s);
            dacc_host_i.send({3'($urandom), 1'b0, 4'h4, d}, 24);
            chk({output_clamp, buffer_powered}, 16'h1);
            chk(mode_configuration, {5'h00, d[10:0]});
            chk({clear_value_select, range_extension_enable, bipolar_twos_coding,
                thermal_supply_shutdown, internal_reference_on, powerup_value_select,
                output_span_select}, {5'h00, d[10:0]});
            chk({forced_active, forced_scale}, {13'h0, 1'b1, exp_scale(d[4:3])});
            dac_code = 16'($urandom);
            over_temp = 1'($urandom);
            #2;
            chk(offset_code, (d[7] && exp_bipolar(d[2:0])) ? dac_code ^ 16'h8000 : dac_code);
            chk(16'(digital_supply_off), 16'(over_temp & d[6]));
            @(posedge sys_clk);
            #1;
            clear_n = 1'b0;
            repeat (2) @(posedge sys_clk);
            #1;
            clear_n = 1'b1;
            repeat (2) @(posedge sys_clk);
            #1;
            chk({forced_active, forced_scale}, {13'h0, 1'b1, exp_scale(d[10:9])});
            dacc_host_i.send({4'h0, 4'h3, 16'($urandom)}, 24);
            chk(16'(forced_active), 16'h0000);
        end
        $display("test control writes done");
        saved = mode_configuration;
        dacc_host_i.send({4'h0, 4'h4, 16'($urandom)}, 23);
        dacc_host_i.send({4'h1, 4'h4, 16'($urandom)}, 24);
        dacc_host_i.send({4'h0, 4'h5, 16'($urandom)}, 24);
        chk(mode_configuration, saved);
        chk({output_clamp, buffer_powered}, 16'h1);
        $display("test refused frames done");
        @(posedge sys_clk);
        #1;
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        chk({output_clamp, buffer_powered}, 16'h2);
        chk(mode_configuration, 16'h0000);
        chk(16'(forced_active), 16'h0000);
        rst = 1'b0;
        dacc_host_i.send({4'h0, 4'h4, 16'h0000}, 24);
        chk({output_clamp, buffer_powered}, 16'h1);
        $display("test hardware reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
